// *** design/sgi_pkg.sv ***
// Constants shared by the serializer side-band control block
package sgi_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] SGI_ADDR_LINK_STATUS = 8'h0C;
	localparam logic [7:0] SGI_ADDR_PIN0_MODE = 8'h0D;
	localparam logic [7:0] SGI_ADDR_PIN12_MODE = 8'h0E;
	localparam logic [7:0] SGI_ADDR_PIN3_MODE = 8'h0F;
	localparam logic [7:0] SGI_ADDR_REG56_MODE = 8'h10;
	localparam logic [7:0] SGI_ADDR_REG78_MODE = 8'h11;
	localparam logic [7:0] SGI_ADDR_LEVELS = 8'h1C;
	localparam logic [7:0] SGI_ADDR_LEVEL8 = 8'h1D;
	localparam logic [7:0] SGI_ADDR_IRQ_EN = 8'hC6;
	localparam logic [7:0] SGI_ADDR_IRQ_STATUS = 8'hC7;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int SGI_NUM_PINS = 8;
	localparam int SGI_NUM_LINK_PINS = 4;
	localparam logic [7:0] SGI_PIN_ADDR [0:7] = '{8'h0D, 8'h0E, 8'h0E, 8'h0F, 8'h10, 8'h10, 8'h11, 8'h11};
	localparam int SGI_PIN_LSB [0:7] = '{0, 0, 4, 0, 0, 4, 0, 4};
	localparam int SGI_LINK_DETECT_BIT = 0;
	localparam int SGI_LEVEL8_BIT = 0;
	localparam int SGI_IRQ_GLOBAL_BIT = 0;
	localparam int SGI_IRQ_LINK_BIT = 1;
	localparam int SGI_IRQ_REMOTE_BIT = 5;

	// ****************************************
	// Mode codes
	// ****************************************
	localparam logic [3:0] SGI_MODE_OUT_LOW = 4'h1;
	localparam logic [3:0] SGI_MODE_OUT_HIGH = 4'h9;
	localparam logic [3:0] SGI_MODE_INPUT = 4'h3;
	localparam logic [3:0] SGI_MODE_FWD = 4'h3;
	localparam logic [3:0] SGI_MODE_BACK = 4'h5;

	// ****************************************
	// Values after reset and synchroniser depth
	// ****************************************
	localparam logic [3:0] SGI_MODE_RESET = 4'h0;
	localparam logic [7:0] SGI_IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] SGI_RDATA_RESET = 8'h00;
	localparam int SGI_SYNC_STAGES = 3;

endpackage

// *** design/sgi_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module sgi_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [WIDTH-1:0] DIN,
	output logic [WIDTH-1:0] DOUT
);

	logic [WIDTH-1:0] ff1_reg, ff1_next;
	logic [WIDTH-1:0] ff2_reg, ff2_next;
	logic [WIDTH-1:0] ff3_reg, ff3_next;
	logic [WIDTH-1:0] stable_reg, stable_next;

	// ****************************************
	// Stages
	// ****************************************
	always_comb begin
		ff1_next = DIN;
		ff2_next = ff1_reg;
		ff3_next = ff2_reg;
	end

	// Only stages two and three are compared; stage one may be metastable
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign stable_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : stable_reg[i];
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (RST) begin
			ff1_reg <= RESET_VAL;
			ff2_reg <= RESET_VAL;
			ff3_reg <= RESET_VAL;
			stable_reg <= RESET_VAL;
		end else begin
			ff1_reg <= ff1_next;
			ff2_reg <= ff2_next;
			ff3_reg <= ff3_next;
			stable_reg <= stable_next;
		end
	end

	assign DOUT = stable_reg;

endmodule

`default_nettype wire

// *** design/sgi_ctrl.sv ***
// Side-band pin, interrupt and link status control of the serializer
`timescale 1ns/100ps
`default_nettype none

// How it works
// RL1: Link pins take code 3 for forward-channel, code 5 for back-channel operation.
// RL2: Link pin modes sit at pin0_mode_cfg[3:0], pin1_pin2_mode_cfg[3:0], pin1_pin2_mode_cfg[7:4], pin3_mode_cfg[3:0].
// RL3: Code 1 drives low, code 9 drives high, code 3 makes a readable input.
// RL4: Register-only pins 5 to 8 use regpin5_6_mode_cfg and regpin7_8_mode_cfg nibbles, same codes.
// RL5: Levels read at pin_input_levels bits 0-3 and 5-7, pin 8 at pin8_input_level bit 0.
// RL6: Register-only pin mode overrides the shared audio input on that pad.
// RL7: Local and remote register access both reach all configuration and levels.
// RL8: Register-only pins never travel across the serial link.
// RL9: Link-detect bit 0 of link_detect_status reads 0 while an interconnect fault exists.
// RL10: Every cable fault kind clears the same single bit, no fault detail.
// RL11: Interrupt output is active low, asserted by any enabled local or remote cause.
// RL12: Software sets interrupt_enable_ctrl bits 5 and 0 to enable remote interrupts.
// RL13: Enabled remote interrupt input going low drives the interrupt output low.
// RL14: Reading the interrupt status clears the pending cause and releases the output.
// RL15: Remote source cleared by software; path re-arms on next falling edge only.
// RL16: Mirror output follows the remote interrupt level, needs no clearing.
// RL17: Mirror output is held high while the link is down.
// RL18: Power-down input low resets every control register to default.
// RL19: Power-down input must stay low at least 3 ms before release.
// RL20: Back channel brings four pin bits at a deserializer-chosen line rate.
// RL21: Undocumented mode codes leave the pin as an undriven input.
module sgi_ctrl (
	input wire logic CLK,
	input wire logic RST,
	input wire logic POWER_DOWN_N,
	input wire logic LOC_WR,
	input wire logic LOC_RD,
	input wire logic [7:0] LOC_ADDR,
	input wire logic [7:0] LOC_WDATA,
	output logic [7:0] LOC_RDATA,
	output logic LOC_RVALID,
	input wire logic RMT_WR,
	input wire logic RMT_RD,
	input wire logic [7:0] RMT_ADDR,
	input wire logic [7:0] RMT_WDATA,
	output logic [7:0] RMT_RDATA,
	output logic RMT_RVALID,
	input wire logic [3:0] GPIO_I,
	output logic [3:0] GPIO_O,
	output logic [3:0] GPIO_OE,
	input wire logic [3:0] GPIO_REG_I,
	output logic [3:0] GPIO_REG_O,
	output logic [3:0] GPIO_REG_OE,
	output logic [3:0] AUD_SDIN,
	output logic [3:0] FWD_GPIO,
	input wire logic [3:0] BC_GPIO,
	input wire logic BC_GPIO_STROBE,
	input wire logic REMOTE_IRQ_IN_N,
	input wire logic LINK_LOCK,
	input wire logic LINK_FAULT,
	output logic IRQ_OUT_N,
	output logic REMOTE_IRQ_MIRROR
);

	// ****************************************
	// Declarations
	// ****************************************
	localparam int NP = sgi_pkg::SGI_NUM_PINS;
	localparam int NL = sgi_pkg::SGI_NUM_LINK_PINS;

	logic [3:0] pad_gpio, pad_greg;
	logic pd_n_s, fault_s, rst_all, link_det;
	logic [NP-1:0] drv_en, drv_val, gpio_mode;

	logic [3:0] mode_reg [0:NP-1];
	logic [3:0] mode_next [0:NP-1];
	logic [7:0] irq_en_reg, irq_en_next;
	logic pend_remote_reg, pend_remote_next;
	logic pend_link_reg, pend_link_next;
	logic [3:0] bc_gpio_reg, bc_gpio_next;
	logic rem_prev_reg, rem_prev_next;
	logic link_prev_reg, link_prev_next;

	logic [3:0] gpio_o_reg, gpio_o_next, gpio_oe_reg, gpio_oe_next;
	logic [3:0] greg_o_reg, greg_o_next, greg_oe_reg, greg_oe_next;
	logic [3:0] aud_reg, aud_next, fwd_reg, fwd_next;
	logic irq_n_reg, irq_n_next, mirror_reg, mirror_next;
	logic [7:0] loc_rdata_reg, loc_rdata_next, rmt_rdata_reg, rmt_rdata_next;
	logic loc_rvalid_reg, loc_rvalid_next, rmt_rvalid_reg, rmt_rvalid_next;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Held apart from power-down so the power-down level itself survives
	sgi_sync #(
		.WIDTH(10),
		.RESET_VAL(10'h100)
	) u_sync (
		.CLK(CLK),
		.RST(RST),
		.DIN({LINK_FAULT, POWER_DOWN_N, GPIO_REG_I, GPIO_I}),
		.DOUT({fault_s, pd_n_s, pad_greg, pad_gpio})
	);

	assign rst_all = RST | ~pd_n_s; // RL18
	assign link_det = ~fault_s; // RL9 RL10

	// ****************************************
	// Per-pin mode decode
	// ****************************************
	genvar k;
	generate
		for (k = 0; k < NP; k++) begin : g_pin
			logic lo, hi, inp;
			assign lo = (mode_reg[k] == sgi_pkg::SGI_MODE_OUT_LOW); // RL3
			assign hi = (mode_reg[k] == sgi_pkg::SGI_MODE_OUT_HIGH); // RL3
			assign inp = (mode_reg[k] == sgi_pkg::SGI_MODE_INPUT); // RL3
			assign gpio_mode[k] = lo | hi | inp;
			if (k < NL) begin : g_link
				logic bc;
				assign bc = (mode_reg[k] == sgi_pkg::SGI_MODE_BACK); // RL1
				assign drv_en[k] = lo | hi | bc; // RL21
				assign drv_val[k] = hi | (bc & bc_gpio_reg[k]); // RL1
			end else begin : g_local
				assign drv_en[k] = lo | hi; // RL4 RL21
				assign drv_val[k] = hi; // RL4
			end
		end
	endgenerate

	// ****************************************
	// Register read mux
	// ****************************************
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < NP; i++) begin
			if (addr == sgi_pkg::SGI_PIN_ADDR[i]) begin
				d[sgi_pkg::SGI_PIN_LSB[i] +: 4] = mode_reg[i]; // RL2 RL4
			end
		end
		case (addr)
			sgi_pkg::SGI_ADDR_LINK_STATUS: begin
				d[sgi_pkg::SGI_LINK_DETECT_BIT] = link_det; // RL9
			end
			sgi_pkg::SGI_ADDR_LEVELS: begin
				d = {pad_greg[2:0], 1'b0, pad_gpio}; // RL5
			end
			sgi_pkg::SGI_ADDR_LEVEL8: begin
				d[sgi_pkg::SGI_LEVEL8_BIT] = pad_greg[3]; // RL5
			end
			sgi_pkg::SGI_ADDR_IRQ_EN: begin
				d = irq_en_reg;
			end
			sgi_pkg::SGI_ADDR_IRQ_STATUS: begin
				d[sgi_pkg::SGI_IRQ_GLOBAL_BIT] = pend_remote_reg | pend_link_reg;
				d[sgi_pkg::SGI_IRQ_LINK_BIT] = pend_link_reg;
				d[sgi_pkg::SGI_IRQ_REMOTE_BIT] = pend_remote_reg;
			end
			default: begin
			end
		endcase
		return d;
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic isr_rd, en_glb, rem_fall, link_drop;
		isr_rd = (LOC_RD & (LOC_ADDR == sgi_pkg::SGI_ADDR_IRQ_STATUS))
			| (RMT_RD & (RMT_ADDR == sgi_pkg::SGI_ADDR_IRQ_STATUS));
		en_glb = irq_en_reg[sgi_pkg::SGI_IRQ_GLOBAL_BIT];
		rem_fall = LINK_LOCK & rem_prev_reg & ~REMOTE_IRQ_IN_N; // RL15
		link_drop = link_prev_reg & ~link_det;

		// Remote port first so a same-cycle local write to a field wins
		for (int i = 0; i < NP; i++) begin
			mode_next[i] = mode_reg[i];
			if (RMT_WR && (RMT_ADDR == sgi_pkg::SGI_PIN_ADDR[i])) begin
				mode_next[i] = RMT_WDATA[sgi_pkg::SGI_PIN_LSB[i] +: 4]; // RL7
			end
			if (LOC_WR && (LOC_ADDR == sgi_pkg::SGI_PIN_ADDR[i])) begin
				mode_next[i] = LOC_WDATA[sgi_pkg::SGI_PIN_LSB[i] +: 4]; // RL7
			end
		end
		irq_en_next = irq_en_reg;
		if (RMT_WR && (RMT_ADDR == sgi_pkg::SGI_ADDR_IRQ_EN)) begin
			irq_en_next = RMT_WDATA; // RL7
		end
		if (LOC_WR && (LOC_ADDR == sgi_pkg::SGI_ADDR_IRQ_EN)) begin
			irq_en_next = LOC_WDATA;
		end

		// Status read clears, but a cause arriving in the same cycle is kept
		pend_remote_next = (pend_remote_reg & ~isr_rd)
			| (rem_fall & en_glb & irq_en_reg[sgi_pkg::SGI_IRQ_REMOTE_BIT]); // RL12 RL13 RL14
		pend_link_next = (pend_link_reg & ~isr_rd)
			| (link_drop & en_glb & irq_en_reg[sgi_pkg::SGI_IRQ_LINK_BIT]); // RL14
		irq_n_next = ~(en_glb & (pend_remote_next | pend_link_next)); // RL11 RL13

		rem_prev_next = REMOTE_IRQ_IN_N;
		link_prev_next = link_det;
		mirror_next = LINK_LOCK ? REMOTE_IRQ_IN_N : 1'b1; // RL16 RL17

		// Back-channel pin bits land once per frame, whatever its line rate
		bc_gpio_next = BC_GPIO_STROBE ? BC_GPIO : bc_gpio_reg; // RL20
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			for (int i = 0; i < NP; i++) begin
				mode_reg[i] <= sgi_pkg::SGI_MODE_RESET; // RL18
			end
			irq_en_reg <= sgi_pkg::SGI_IRQ_EN_RESET;
			pend_remote_reg <= 1'b0;
			pend_link_reg <= 1'b0;
			bc_gpio_reg <= 4'h0;
			rem_prev_reg <= 1'b1;
			link_prev_reg <= 1'b0;
			irq_n_reg <= 1'b1;
			mirror_reg <= 1'b1;
		end else begin
			for (int i = 0; i < NP; i++) begin
				mode_reg[i] <= mode_next[i];
			end
			irq_en_reg <= irq_en_next;
			pend_remote_reg <= pend_remote_next;
			pend_link_reg <= pend_link_next;
			bc_gpio_reg <= bc_gpio_next;
			rem_prev_reg <= rem_prev_next;
			link_prev_reg <= link_prev_next;
			irq_n_reg <= irq_n_next;
			mirror_reg <= mirror_next;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Registered so a mode write never glitches a pad mid-cycle
	always_comb begin
		for (int i = 0; i < NL; i++) begin
			gpio_o_next[i] = drv_val[i];
			gpio_oe_next[i] = drv_en[i];
			fwd_next[i] = (mode_reg[i] == sgi_pkg::SGI_MODE_FWD) & pad_gpio[i]; // RL1
			greg_o_next[i] = drv_val[NL + i]; // RL8
			greg_oe_next[i] = drv_en[NL + i];
			aud_next[i] = gpio_mode[NL + i] ? 1'b0 : pad_greg[i]; // RL6
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			gpio_o_reg <= 4'h0;
			gpio_oe_reg <= 4'h0;
			greg_o_reg <= 4'h0;
			greg_oe_reg <= 4'h0;
			aud_reg <= 4'h0;
			fwd_reg <= 4'h0;
		end else begin
			gpio_o_reg <= gpio_o_next;
			gpio_oe_reg <= gpio_oe_next;
			greg_o_reg <= greg_o_next;
			greg_oe_reg <= greg_oe_next;
			aud_reg <= aud_next;
			fwd_reg <= fwd_next;
		end
	end

	// ****************************************
	// Read ports
	// ****************************************
	always_comb begin
		loc_rdata_next = LOC_RD ? reg_read(LOC_ADDR) : loc_rdata_reg; // RL7
		rmt_rdata_next = RMT_RD ? reg_read(RMT_ADDR) : rmt_rdata_reg; // RL7
		loc_rvalid_next = LOC_RD;
		rmt_rvalid_next = RMT_RD;
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			loc_rdata_reg <= sgi_pkg::SGI_RDATA_RESET;
			rmt_rdata_reg <= sgi_pkg::SGI_RDATA_RESET;
			loc_rvalid_reg <= 1'b0;
			rmt_rvalid_reg <= 1'b0;
		end else begin
			loc_rdata_reg <= loc_rdata_next;
			rmt_rdata_reg <= rmt_rdata_next;
			loc_rvalid_reg <= loc_rvalid_next;
			rmt_rvalid_reg <= rmt_rvalid_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign GPIO_O = gpio_o_reg;
	assign GPIO_OE = gpio_oe_reg;
	assign GPIO_REG_O = greg_o_reg;
	assign GPIO_REG_OE = greg_oe_reg;
	assign AUD_SDIN = aud_reg;
	assign FWD_GPIO = fwd_reg;
	assign IRQ_OUT_N = irq_n_reg;
	assign REMOTE_IRQ_MIRROR = mirror_reg;
	assign LOC_RDATA = loc_rdata_reg;
	assign LOC_RVALID = loc_rvalid_reg;
	assign RMT_RDATA = rmt_rdata_reg;
	assign RMT_RVALID = rmt_rvalid_reg;

endmodule

`default_nettype wire

// *** sim/sgi_ctrl_checker.sv ***
// Concurrent checks on the ports of the side-band control block
`timescale 1ns/100ps
`default_nettype none
module sgi_ctrl_checker (
	input wire logic CLK,
	input wire logic RST,
	input wire logic POWER_DOWN_N,
	input wire logic LOC_WR,
	input wire logic LOC_RD,
	input wire logic [7:0] LOC_ADDR,
	input wire logic [7:0] LOC_WDATA,
	input wire logic [7:0] LOC_RDATA,
	input wire logic LOC_RVALID,
	input wire logic RMT_WR,
	input wire logic RMT_RD,
	input wire logic [7:0] RMT_ADDR,
	input wire logic [7:0] RMT_WDATA,
	input wire logic RMT_RVALID,
	input wire logic [3:0] GPIO_OE,
	input wire logic [3:0] GPIO_REG_OE,
	input wire logic REMOTE_IRQ_IN_N,
	input wire logic LINK_LOCK,
	input wire logic IRQ_OUT_N,
	input wire logic REMOTE_IRQ_MIRROR
);
	// ****
	// Power state and enable shadow
	// ****
	logic [2:0] up_reg, up_next, lo_reg, lo_next;
	logic [7:0] en_reg, en_next;
	logic ok, wr_en, rd_st;
	// Checks pause around power-down, the pin filter makes its edges fuzzy
	assign ok = up_reg == 3'h7;
	assign wr_en = (LOC_WR && LOC_ADDR == 8'hC6) || (RMT_WR && RMT_ADDR == 8'hC6);
	assign rd_st = (LOC_RD && LOC_ADDR == 8'hC7) || (RMT_RD && RMT_ADDR == 8'hC7);
	always_comb begin
		up_next = (RST || !POWER_DOWN_N) ? 3'h0 : up_reg + {2'h0, !ok};
		lo_next = POWER_DOWN_N ? 3'h0 : lo_reg + {2'h0, lo_reg != 3'h7};
		en_next = en_reg;
		if (RST || !ok) en_next = 8'h00;
		else if (LOC_WR && LOC_ADDR == 8'hC6) en_next = LOC_WDATA;
		else if (RMT_WR && RMT_ADDR == 8'hC6) en_next = RMT_WDATA;
	end
	always_ff @(posedge CLK) begin
		up_reg <= up_next;
		lo_reg <= lo_next;
		en_reg <= en_next;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_loc_answer: assert property (ok && LOC_RD |=> LOC_RVALID) else $error("local read unanswered");
	a_rmt_answer: assert property (ok && RMT_RD |=> RMT_RVALID) else $error("remote read unanswered");
	a_rdata_hold: assert property (ok && !LOC_RD |=> $stable(LOC_RDATA)) else $error("read data moved");
	a_mirror_follow: assert property (ok && LINK_LOCK |=> REMOTE_IRQ_MIRROR == $past(REMOTE_IRQ_IN_N))
		else $error("mirror not following");
	a_mirror_down: assert property (!LINK_LOCK |=> REMOTE_IRQ_MIRROR) else $error("mirror low, link down");
	a_irq_raise: assert property (ok && LINK_LOCK && en_reg[0] && en_reg[5] && $fell(REMOTE_IRQ_IN_N)
		|=> !IRQ_OUT_N) else $error("interrupt not raised");
	a_irq_hold: assert property (ok && !IRQ_OUT_N && !rd_st && !wr_en |=> !IRQ_OUT_N)
		else $error("interrupt dropped early");
	a_irq_drop: assert property (ok && rd_st && !en_reg[1] && $stable(REMOTE_IRQ_IN_N) |=> IRQ_OUT_N)
		else $error("interrupt kept after status read");
	a_irq_quiet: assert property (ok && IRQ_OUT_N && !en_reg[1] && !wr_en && !$past(wr_en)
		&& !$fell(REMOTE_IRQ_IN_N) |=> IRQ_OUT_N) else $error("interrupt without cause");
	a_pd_quiet: assert property (lo_reg == 3'h7 |-> GPIO_OE == 4'h0 && GPIO_REG_OE == 4'h0 && IRQ_OUT_N)
		else $error("outputs active in power-down");
endmodule
`default_nettype wire

// *** sim/sgi_deser_model.sv ***
// Behavioural deserializer at the far end of the serial link
`timescale 1ns/100ps
`default_nettype none
module sgi_deser_model #(
	parameter int FRAME = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_up,
	input wire logic irq_req,
	input wire logic [3:0] bc_val,
	output logic lock,
	output logic irq_n,
	output logic strobe,
	output logic [3:0] bc_gpio
);
	// ****
	// Back-channel frames
	// ****
	// Frame spacing stands for the chosen line rate
	int cnt;
	logic frame;
	assign frame = link_up && cnt == FRAME - 1;
	always_ff @(posedge clk) begin
		cnt <= (rst || !link_up || frame) ? 0 : cnt + 1;
		strobe <= frame;
		// Outside a frame the bits are junk, so they toggle
		bc_gpio <= rst ? 4'h0 : frame ? bc_val : ~bc_gpio;
		lock <= link_up;
		irq_n <= !irq_req;
	end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the side-band control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int FRAME = 5;
	localparam logic [3:0] CODES [0:3] = '{4'h1, 4'h9, 4'h3, 4'h5};
	localparam logic [7:0] CFG [0:5] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'hC6};
	localparam logic [7:0] MASK [0:5] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [7:0] INMODE [0:5] = '{8'h03, 8'h33, 8'h03, 8'h33, 8'h33, 8'h00};
	logic clk = 1'b0, rst = 1'b1, pd_n = 1'b1, fault = 1'b0, link_up = 1'b1, irq_req = 1'b0;
	logic lwr = 1'b0, lrd = 1'b0, rwr = 1'b0, rrd = 1'b0, lrv, rrv, irq_n, mirror, lock, rirq_n, strobe;
	logic [7:0] la = 8'h00, lw = 8'h00, ra = 8'h00, rw = 8'h00, lrdata, rrdata, d;
	logic [3:0] pads = 4'h0, rpads = 4'h0, bc_val = 4'h0, gi, go, goe, gri, gro, groe, aud, fwd, bc, c;
	bit port;
	int err_count = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	// Pad level: the design wins while it drives
	assign gi = (goe & go) | (~goe & pads);
	assign gri = (groe & gro) | (~groe & rpads);
	sgi_ctrl i_sgi_ctrl (.CLK(clk), .RST(rst), .POWER_DOWN_N(pd_n),
		.LOC_WR(lwr), .LOC_RD(lrd), .LOC_ADDR(la), .LOC_WDATA(lw), .LOC_RDATA(lrdata), .LOC_RVALID(lrv),
		.RMT_WR(rwr), .RMT_RD(rrd), .RMT_ADDR(ra), .RMT_WDATA(rw), .RMT_RDATA(rrdata), .RMT_RVALID(rrv),
		.GPIO_I(gi), .GPIO_O(go), .GPIO_OE(goe), .GPIO_REG_I(gri), .GPIO_REG_O(gro), .GPIO_REG_OE(groe),
		.AUD_SDIN(aud), .FWD_GPIO(fwd), .BC_GPIO(bc), .BC_GPIO_STROBE(strobe), .REMOTE_IRQ_IN_N(rirq_n),
		.LINK_LOCK(lock), .LINK_FAULT(fault), .IRQ_OUT_N(irq_n), .REMOTE_IRQ_MIRROR(mirror));
	sgi_deser_model #(.FRAME(FRAME)) i_sgi_deser_model (.clk(clk), .rst(rst), .link_up(link_up),
		.irq_req(irq_req), .bc_val(bc_val), .lock(lock), .irq_n(rirq_n), .strobe(strobe), .bc_gpio(bc));
	// ****
	// Tasks and expectations
	// ****
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input bit p, input logic [7:0] a, input logic [7:0] v);
		if (p) {rwr, ra, rw} = {1'b1, a, v};
		else {lwr, la, lw} = {1'b1, a, v};
		tick(1);
		{rwr, lwr} = 2'b00;
		tick(1);
	endtask
	task automatic rd(input bit p, input logic [7:0] a, input logic [7:0] e);
		if (p) {rrd, ra} = {1'b1, a};
		else {lrd, la} = {1'b1, a};
		tick(1);
		{rrd, lrd} = 2'b00;
		chk("read valid", 8'h01, {7'h00, p ? rrv : lrv});
		chk("read data", e, p ? rrdata : lrdata);
		tick(1);
	endtask
	function automatic logic [7:0] pin_exp(input int p, input logic [3:0] m);
		logic oe, gm;
		oe = m == 4'h1 || m == 4'h9 || (m == 4'h5 && p < 4);
		// Audio path sees the pad only while the pin is out of gpio mode
		gm = m == 4'h1 || m == 4'h9 || m == 4'h3;
		return {4'h0, p >= 4 && !gm && rpads[p % 4], oe, oe && (m == 4'h9 || (m == 4'h5 && bc_val[p % 4])),
			p < 4 && m == 4'h3 && pads[p % 4]};
	endfunction
	function automatic logic [7:0] pin_got(input int p);
		if (p < 4) return {4'h0, 1'b0, goe[p % 4], goe[p % 4] & go[p % 4], fwd[p % 4]};
		return {4'h0, aud[p % 4], groe[p % 4], groe[p % 4] & gro[p % 4], |fwd};
	endfunction
	task automatic print_verdict;
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict;
	end
	initial begin
		void'($urandom(69));
		tick(16);
		rst = 1'b0;
		tick(8);
		wr(0, 8'h55, 8'hFF);
		wr(1, 8'h0C, 8'h00);
		rd(0, 8'h0C, 8'h01);
		rd(1, 8'h55, 8'h00);
		rd(0, 8'hC7, 8'h00);
		for (int i = 0; i < 6; i++) rd(i % 2, CFG[i], 8'h00);
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(i % 2, CFG[i], d);
			rd(!(i % 2), CFG[i], d & MASK[i]);
		end
		pads = 4'($urandom);
		rpads = 4'($urandom);
		for (int i = 0; i < 6; i++) wr(i % 2, CFG[i], INMODE[i]);
		tick(6);
		rd(0, 8'h1C, {rpads[2:0], 1'b0, pads});
		rd(1, 8'h1D, {7'h00, rpads[3]});
		chk("audio input", 8'h00, {4'h0, aud});
		bc_val = 4'($urandom);
		tick(3 * FRAME);
		for (int p = 0; p < 8; p++)
			for (int k = 0; k < 5; k++) begin
				// Even codes are never documented, so they stand for reserved ones
				c = k < 4 ? CODES[k] : 4'(2 * ($urandom % 8));
				port = 1'($urandom);
				d = 8'(c) << sgi_pkg::SGI_PIN_LSB[p];
				wr(port, sgi_pkg::SGI_PIN_ADDR[p], d);
				// Pad filter needs a few edges before forwarded and audio levels settle
				tick(6);
				chk("pin state", pin_exp(p, c), pin_got(p));
				rd(!port, sgi_pkg::SGI_PIN_ADDR[p], d);
			end
		wr(0, 8'hC6, 8'h21);
		irq_req = 1'b1;
		tick(3);
		chk("irq out", 8'h00, {7'h00, irq_n});
		chk("mirror", 8'h00, {7'h00, mirror});
		rd(1, 8'hC7, 8'h21);
		tick(5);
		chk("irq out", 8'h01, {7'h00, irq_n});
		chk("mirror", 8'h00, {7'h00, mirror});
		irq_req = 1'b0;
		tick(3);
		irq_req = 1'b1;
		tick(3);
		chk("irq out", 8'h00, {7'h00, irq_n});
		rd(0, 8'hC7, 8'h21);
		wr(1, 8'hC6, 8'h20);
		irq_req = 1'b0;
		tick(3);
		irq_req = 1'b1;
		tick(3);
		chk("irq out", 8'h01, {7'h00, irq_n});
		link_up = 1'b0;
		tick(3);
		chk("mirror", 8'h01, {7'h00, mirror});
		wr(0, 8'hC6, 8'h03);
		{link_up, irq_req, fault} = 3'b101;
		tick(8);
		chk("irq out", 8'h00, {7'h00, irq_n});
		rd(1, 8'h0C, 8'h00);
		rd(0, 8'hC7, 8'h03);
		chk("irq out", 8'h01, {7'h00, irq_n});
		fault = 1'b0;
		tick(8);
		rd(0, 8'h0C, 8'h01);
		wr(0, 8'h0D, 8'h09);
		wr(1, 8'hC6, 8'h21);
		// Hold cut far below 3 ms to fit the run; the device does not time it
		pd_n = 1'b0;
		tick(20);
		chk("drive in power-down", 8'h00, {4'h0, goe});
		pd_n = 1'b1;
		tick(8);
		rd(0, 8'h0D, 8'h00);
		rd(1, 8'hC6, 8'h00);
		print_verdict;
	end
endmodule
bind sgi_ctrl sgi_ctrl_checker i_sgi_ctrl_checker (.CLK(CLK), .RST(RST), .POWER_DOWN_N(POWER_DOWN_N),
	.LOC_WR(LOC_WR), .LOC_RD(LOC_RD), .LOC_ADDR(LOC_ADDR), .LOC_WDATA(LOC_WDATA), .LOC_RDATA(LOC_RDATA),
	.LOC_RVALID(LOC_RVALID), .RMT_WR(RMT_WR), .RMT_RD(RMT_RD), .RMT_ADDR(RMT_ADDR), .RMT_WDATA(RMT_WDATA),
	.RMT_RVALID(RMT_RVALID), .GPIO_OE(GPIO_OE), .GPIO_REG_OE(GPIO_REG_OE), .REMOTE_IRQ_IN_N(REMOTE_IRQ_IN_N),
	.LINK_LOCK(LINK_LOCK), .IRQ_OUT_N(IRQ_OUT_N), .REMOTE_IRQ_MIRROR(REMOTE_IRQ_MIRROR));
`default_nettype wire
